// [hw/prot_stage.sv]
// Generic protection stage: pick-up with hysteresis, blocking, and
// instant, definite-delay or inverse-time trip timing with release.
// Assumes an APB master on mclk, magnitude and fault type valid on mclk,
// and blocking and test-mode levels arriving asynchronously on pins.
//
// Functional notes
// - Each evaluation compares magnitude with setting and picks up past it.
// - Once picked up, drop only past 97 percent of the setting, or 103 percent in under mode.
// - Start follows pick-up only when blocking is inactive.
// - Blocking is sampled first in each program cycle.
// - Pick-up while blocked shows blocked and skips all timing.
// - Blocking during start drops start and runs release timing.
// - Each blocking of a pick-up outside release timing raises a display event and a stamped record.
// - In test mode a software switch can drive blocking.
// - Instant operation trips in the same evaluation as start.
// - Definite delay trips after the set delay of steady pick-up.
// - Inverse time takes its delay from the magnitude ratio curve.
// - Inverse time never trips before the minimum delay; zero disables.
// - Delay type 0 is definite, 1 inverse; reset default definite.
// - Delay counts in 5 ms steps, default 40 ms.
// - In definite time, zero delay gives instant operation, nonzero gives delayed.
// - Curve family 0 IEC, 1 IEEE; only used in inverse time.
// - Pick-up reset before trip holds timing and runs release; the timer clears only when release expires.
// - Inverse delays scale by a time dial in 0.01 steps.
`timescale 1ns/1ns
`include "prot_params.svh"
module prot_stage
#(
  parameter int unsigned CYCLE_CLKS = `CYCLE_CLKS
)
(
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [15:0]     meas_mag,
  input  wire logic [2:0]      fault_type,
  input  wire logic            blk_in,
  input  wire logic            test_mode_in,
  output prot_pkg::stat_s      stat,
  output logic                 disp_evt,
  output logic                 blk_evt,
  output prot_pkg::evt_s       evt_rec
);

  import prot_pkg::*;

  localparam int TW = $clog2(CYCLE_CLKS);

  logic            rst_s1;
  logic            rst_sync_b;
  logic [TW-1:0]   tick_cnt;
  logic            tick;
  logic [31:0]     stamp;
  phase_e          phase;
  stage_e          stage;
  stage_e          next_stage;
  ctrl_s           ctrl;
  logic [15:0]     pick_set;
  logic [19:0]     dly_set;
  logic [11:0]     tdial;
  logic [19:0]     rel_set;
  logic [19:0]     cnt;
  logic [19:0]     next_cnt;
  logic [19:0]     rel_cnt;
  logic [19:0]     next_rel_cnt;
  logic [15:0]     mag_q;
  logic [15:0]     start_mag;
  logic            blk_pin;
  logic            test_mode;
  logic            blk_q;
  logic            picked;
  logic            next_picked;
  logic [23:0]     mag100;
  logic [3:0]      bucket;
  logic [15:0]     hit;
  logic [15:0]     num;
  logic [15:0]     den;
  logic [15:0]     curve_q;
  logic            blk_now;
  logic            apb_acc;
  logic            is_tbl;
  logic            tbl_rd;
  logic            tbl_rdy;
  logic            mem_wr;
  logic [4:0]      mem_rd_addr;
  logic            eval_rd;
  logic            known;

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ----------------------------------------------------------------------

  // Release the reset through two flip-flops.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_s1     <= 1'b1;
      rst_sync_b <= rst_s1;
    end
  end

  pin_sync u_blk_sync
  (
    .mclk  (mclk),
    .rst_b (rst_sync_b),
    .pin   (blk_in),
    .level (blk_pin)
  );

  pin_sync u_test_sync
  (
    .mclk  (mclk),
    .rst_b (rst_sync_b),
    .pin   (test_mode_in),
    .level (test_mode)
  );

  // ----------------------------------------------------------------------
  // Program cycle tick and time stamp.
  // ----------------------------------------------------------------------

  // Divide the clock down to one evaluation per program cycle.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      tick_cnt <= '0;
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  assign tick = (tick_cnt == TW'(CYCLE_CLKS - 1));

  // Free-running count of program cycles used to stamp events.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      stamp <= 32'h0000_0000;
    else if (tick)
      stamp <= stamp + 32'h0000_0001;
  end

  // ----------------------------------------------------------------------
  // APB register file.
  // ----------------------------------------------------------------------

  // Decode whether an address names a table word or a known register.
  function automatic logic reg_known(input logic [7:0] a, input logic wr);
    case (a)
      `OFS_CTRL, `OFS_PICKUP, `OFS_DELAY, `OFS_TDIAL, `OFS_RELEASE:
        reg_known = 1'b1;
      `OFS_STATUS, `OFS_COUNT, `OFS_EVTIME:
        reg_known = !wr;
      default:
        reg_known = a[`TBL_SEL_BIT] && (a[1:0] == 2'b00);
    endcase
  endfunction

  assign apb_acc = psel && penable;
  assign is_tbl  = paddr[`TBL_SEL_BIT];
  assign known   = reg_known(paddr, pwrite);
  assign tbl_rd  = apb_acc && is_tbl && !pwrite && known;
  assign pready  = apb_acc && (!tbl_rd || tbl_rdy);
  assign pslverr = pready && !known;
  assign mem_wr  = pready && pwrite && is_tbl && known;

  // Table reads wait one cycle for the memory, longer if evaluation uses it.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      tbl_rdy <= 1'b0;
    else
      tbl_rdy <= tbl_rd && !tbl_rdy && !eval_rd;
  end

  // Writable settings; a write lands on the completing access edge.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      ctrl     <= `CTRL_RST;
      pick_set <= `PICKUP_RST;
      dly_set  <= `DELAY_RST;
      tdial    <= `TDIAL_RST;
      rel_set  <= `RELEASE_RST;
    end
    else if (pready && pwrite)
    begin
      case (paddr)
        `OFS_CTRL:    ctrl     <= pwdata[3:0];
        `OFS_PICKUP:  pick_set <= pwdata[15:0];
        `OFS_DELAY:   dly_set  <= pwdata[19:0];
        `OFS_TDIAL:   tdial    <= pwdata[11:0];
        `OFS_RELEASE: rel_set  <= pwdata[19:0];
        default:      ;
      endcase
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (is_tbl && known)
      prdata = {16'h0000, curve_q};
    else
    begin
      case (paddr)
        `OFS_CTRL:    prdata = {28'h0000000, ctrl};
        `OFS_PICKUP:  prdata = {16'h0000, pick_set};
        `OFS_DELAY:   prdata = {12'h000, dly_set};
        `OFS_TDIAL:   prdata = {20'h00000, tdial};
        `OFS_RELEASE: prdata = {12'h000, rel_set};
        `OFS_STATUS:  prdata = {18'h00000, test_mode, bucket, stage, stat};
        `OFS_COUNT:   prdata = {12'h000, cnt};
        `OFS_EVTIME:  prdata = evt_rec.stamp;
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Curve table.
  // ----------------------------------------------------------------------

  assign eval_rd     = (phase == PH_PICK);
  assign mem_rd_addr = eval_rd ? {ctrl.curve, bucket} : paddr[6:2];

  curve_mem u_curve
  (
    .mclk    (mclk),
    .rst_b   (rst_sync_b),
    .wr_en   (mem_wr),
    .wr_addr (paddr[6:2]),
    .wr_data (pwdata[15:0]),
    .rd_addr (mem_rd_addr),
    .rd_data (curve_q)
  );

  // ----------------------------------------------------------------------
  // Evaluation sequence.
  // ----------------------------------------------------------------------

  // Step through block sample, pick-up and timing once per tick.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      phase <= PH_IDLE;
    else
    begin
      case (phase)
        PH_IDLE:  phase <= tick ? PH_BLOCK : PH_IDLE;
        PH_BLOCK: phase <= PH_PICK;
        PH_PICK:  phase <= PH_TIME;
        PH_TIME:  phase <= PH_IDLE;
        default:  phase <= PH_IDLE;
      endcase
    end
  end

  // Software switch may drive blocking while test mode is active.
  assign blk_now = blk_pin || (test_mode && ctrl.sw_blk);

  // Sample blocking and magnitude before any evaluation.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      blk_q <= 1'b0;
      mag_q <= 16'h0000;
    end
    else if (phase == PH_BLOCK)
    begin
      blk_q <= blk_now;
      mag_q <= meas_mag;
    end
  end

  // ----------------------------------------------------------------------
  // Pick-up with fixed hysteresis and ratio bucket.
  // ----------------------------------------------------------------------

  assign mag100 = 24'(mag_q) * 24'(`PCT_FULL);

  // Over or under pick-up; hold until past the reset ratio threshold.
  always_comb
  begin
    next_picked = picked;
    if (!ctrl.under)
    begin
      if (picked)
        next_picked = mag100 >= 24'(pick_set) * 24'(`PCT_DROP_OVER);
      else
        next_picked = mag100 > 24'(pick_set) * 24'(`PCT_FULL);
    end
    else
    begin
      if (picked)
        next_picked = mag100 <= 24'(pick_set) * 24'(`PCT_DROP_UNDR);
      else
        next_picked = mag100 < 24'(pick_set) * 24'(`PCT_FULL);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      picked <= 1'b0;
    else if (phase == PH_PICK)
      picked <= next_picked;
  end

  // Ratio in quarter steps from 1 to 4.75, taken as bucket for the curve.
  assign num = ctrl.under ? pick_set : mag_q;
  assign den = ctrl.under ? mag_q : pick_set;
  assign hit[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++)
    begin : g_ratio
      assign hit[gi] = (24'({num, 2'b00}) >= 24'(den) * 24'(4 + gi));
    end
  endgenerate

  always_comb
  begin
    bucket = 4'h0;
    for (int i = 1; i < 16; i++)
      bucket = bucket + 4'(hit[i]);
  end

  // ----------------------------------------------------------------------
  // Stage state and timing.
  // ----------------------------------------------------------------------

  // True once the elapsed program cycles cover the selected delay.
  function automatic logic delay_met(input logic [19:0] c);
    if (!ctrl.dly_type)
      delay_met = (c >= dly_set);
    else
      delay_met = (c >= dly_set) &&
        (32'(c) * 32'(`PCT_FULL) >= 32'(curve_q) * 32'(tdial));
  endfunction

  // Next stage, trip timer and release timer for this evaluation.
  always_comb
  begin
    next_stage   = stage;
    next_cnt     = cnt;
    next_rel_cnt = rel_cnt;
    case (stage)
      ST_IDLE:
      begin
        next_cnt = 20'h00000;
        if (picked && blk_q)
          next_stage = ST_BLOCKED;
        else if (picked)
          next_stage = delay_met(20'h00000) ? ST_TRIP : ST_START;
      end
      ST_START:
      begin
        if (!picked || blk_q)
        begin
          next_stage   = ST_RELEASE;
          next_rel_cnt = 20'h00000;
        end
        else
        begin
          next_cnt = cnt + 20'h00001;
          if (delay_met(next_cnt))
            next_stage = ST_TRIP;
        end
      end
      ST_TRIP:
      begin
        if (!picked || blk_q)
        begin
          next_stage = ST_IDLE;
          next_cnt   = 20'h00000;
        end
      end
      ST_BLOCKED:
        if (!picked)
          next_stage = ST_IDLE;
      ST_RELEASE:
      begin
        if (picked && !blk_q)
          next_stage = ST_START;
        else if (rel_cnt >= rel_set)
        begin
          next_stage = ST_IDLE;
          next_cnt   = 20'h00000;
        end
        else
          next_rel_cnt = rel_cnt + 20'h00001;
      end
      default:
      begin
        next_stage = ST_IDLE;
        next_cnt   = 20'h00000;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      stage   <= ST_IDLE;
      cnt     <= 20'h00000;
      rel_cnt <= 20'h00000;
    end
    else if (phase == PH_TIME)
    begin
      stage   <= next_stage;
      cnt     <= next_cnt;
      rel_cnt <= next_rel_cnt;
    end
  end

  // Latch the magnitude at which the stage picked up.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      start_mag <= 16'h0000;
    else if (phase == PH_TIME && stage == ST_IDLE && picked)
      start_mag <= mag_q;
  end

  // ----------------------------------------------------------------------
  // Outputs and blocking events.
  // ----------------------------------------------------------------------

  // Registered stage flags, refreshed after each evaluation.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      stat <= '0;
    else if (phase == PH_TIME)
    begin
      stat.pickup  <= picked;
      stat.start   <= (next_stage == ST_START) ||
                      (next_stage == ST_TRIP);
      stat.blocked <= (next_stage == ST_BLOCKED);
      stat.trip    <= (next_stage == ST_TRIP);
    end
  end

  // One-cycle event pulses with a stamped record on each blocking of a pick-up, except while in release.
  always_ff @(posedge mclk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      disp_evt <= 1'b0;
      blk_evt  <= 1'b0;
      evt_rec  <= '0;
    end
    else if (phase == PH_TIME && picked && blk_q &&
             stage != ST_BLOCKED && stage != ST_RELEASE)
    begin
      disp_evt      <= 1'b1;
      blk_evt       <= 1'b1;
      evt_rec.stamp <= stamp;
      evt_rec.mag   <= (stage == ST_IDLE) ? mag_q : start_mag;
      evt_rec.fault <= fault_type;
    end
    else
    begin
      disp_evt <= 1'b0;
      blk_evt  <= 1'b0;
    end
  end

endmodule

// [hw/prot_params.svh]
// Constants of the protection stage: register offsets, field positions,
// reset values and timing counts.
// Assumes a 50 MHz system clock and word-aligned APB byte addresses.
`ifndef PROT_PARAMS_SVH
`define PROT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_PICKUP    8'h04
`define OFS_DELAY     8'h08
`define OFS_TDIAL     8'h0C
`define OFS_RELEASE   8'h10
`define OFS_STATUS    8'h14
`define OFS_COUNT     8'h18
`define OFS_EVTIME    8'h1C
`define TBL_SEL_BIT   7

// ----------------------------------------------------------------------
// Control field positions.
// ----------------------------------------------------------------------
`define CTRL_DLY_TYPE 0
`define CTRL_CURVE    1
`define CTRL_UNDER    2
`define CTRL_SW_BLK   3

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define CTRL_RST      4'h0
`define PICKUP_RST    16'h0100
`define DELAY_RST     20'h00008
`define TDIAL_RST     12'h005
`define RELEASE_RST   20'h00000
`define CURVE_RST     16'h0064

// ----------------------------------------------------------------------
// Ratios in percent and timing.
// ----------------------------------------------------------------------
`define PCT_FULL      8'h64
`define PCT_DROP_OVER 8'h61
`define PCT_DROP_UNDR 8'h67
`define CLK_MHZ       50
`define CYCLE_TIME_US 5000
`define CYCLE_CLKS    (`CYCLE_TIME_US * `CLK_MHZ)
`define BLK_LEAD_MS   5
`define BLK_LEAD_TICKS ((`BLK_LEAD_MS * 1000) / `CYCLE_TIME_US)

`endif

// [hw/prot_pkg.sv]
// Types shared by the protection stage design files.
// Assumes prot_params.svh supplies the numeric constants.
package prot_pkg;

  // Phase of one evaluation (program) cycle.
  typedef enum logic [3:0]
  {
    PH_IDLE  = 4'b0001,
    PH_BLOCK = 4'b0010,
    PH_PICK  = 4'b0100,
    PH_TIME  = 4'b1000
  } phase_e;

  // Stage state.
  typedef enum logic [4:0]
  {
    ST_IDLE    = 5'b00001,
    ST_START   = 5'b00010,
    ST_TRIP    = 5'b00100,
    ST_BLOCKED = 5'b01000,
    ST_RELEASE = 5'b10000
  } stage_e;

  // Control register fields.
  typedef struct packed
  {
    logic sw_blk;
    logic under;
    logic curve;
    logic dly_type;
  } ctrl_s;

  // Stage output flags.
  typedef struct packed
  {
    logic pickup;
    logic start;
    logic blocked;
    logic trip;
  } stat_s;

  // Blocking event record.
  typedef struct packed
  {
    logic [31:0] stamp;
    logic [15:0] mag;
    logic [2:0]  fault;
  } evt_s;

endpackage

// [hw/pin_sync.sv]
// Three-stage synchroniser for one asynchronous pin.
// Assumes an active-low synchronous-domain reset; output settles when
// the second and third stages agree.
`timescale 1ns/1ns
module pin_sync
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);

  logic s1;
  logic s2;
  logic s3;

  // Shift chain; only the second stage reads the first.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once the two later stages agree.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      level <= 1'b0;
    else if (s2 == s3)
      level <= s3;
  end

endmodule

// [hw/curve_mem.sv]
// Inverse-curve table: 32 words of 16 bits, one write and one read port.
// Assumes the caller holds the read address stable for one cycle; read
// data appear from a register one cycle later.
`timescale 1ns/1ns
`include "prot_params.svh"
module curve_mem
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [4:0]  rd_addr,
  output logic [15:0]      rd_data
);

  logic [15:0] mem [32];

  // Table storage, loaded with a flat default curve at reset.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 32; i++)
        mem[i] <= `CURVE_RST;
    end
    else if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read port.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= 16'h0000;
    else
      rd_data <= mem[rd_addr];
  end

endmodule

// [bench/prot_stage_asserts.sv]
// Checker for the protection stage outputs, bound to its ports.
// Assumes evaluations come CYCLE_CLKS clocks apart.
`timescale 1ns/1ns
module prot_stage_asserts
#(
  parameter int unsigned CYCLE_CLKS = 20
)
(
  input wire logic            mclk,
  input wire logic            rst_b,
  input wire prot_pkg::stat_s stat,
  input wire logic            disp_evt,
  input wire logic            blk_evt,
  input wire prot_pkg::evt_s  evt_rec
);
  import prot_pkg::*;

  logic [31:0] gap;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Counts clocks since the stage flags last moved.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      gap <= 32'h0;
    else if ($changed(stat))
      gap <= 32'h1;
    else if (gap != 32'h0)
      gap <= gap + 32'h1;
  end

  // ------
  // Properties
  // ------
  evt_pair_a: assert property (disp_evt == blk_evt)
    else $error("event pair split");
  evt_pulse_a: assert property (blk_evt |=> !blk_evt)
    else $error("event pulse too wide");
  rec_hold_a: assert property ($changed(evt_rec) |-> blk_evt)
    else $error("record moved alone");
  blk_start_a: assert property (blk_evt |-> !stat.start)
    else $error("start kept on blocking");
  start_pick_a: assert property ($rose(stat.start) |-> stat.pickup)
    else $error("start without pick-up");
  trip_start_a: assert property (stat.trip |-> stat.start)
    else $error("trip without start");
  blk_excl_a: assert property (stat.blocked |-> stat[2:0] == 3'h2)
    else $error("blocked with timing");
  eval_gap_a: assert property
    ($changed(stat) && gap != 32'h0 |-> gap >= CYCLE_CLKS)
    else $error("flags moved between evaluations");

  trip_c: cover property ($rose(stat.trip));
  block_c: cover property ($rose(stat.blocked));
  event_c: cover property (blk_evt && stat.pickup);
endmodule

bind prot_stage prot_stage_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u
(
  .mclk     (mclk),
  .rst_b    (rst_b),
  .stat     (stat),
  .disp_evt (disp_evt),
  .blk_evt  (blk_evt),
  .evt_rec  (evt_rec)
);

// [bench/meas_model.sv]
// Measurement path and blocking matrix in front of the stage.
// Assumes the bench sets its levels just after a clock edge.
`timescale 1ns/1ns
module meas_model
(
  input  wire logic [15:0] mag_req,
  input  wire logic        blk_req,
  input  wire logic        tm_req,
  output logic [15:0]      meas_mag,
  output logic [2:0]       fault_type,
  output logic             blk_in,
  output logic             test_mode_in
);
  // Levels pass straight on; blocking reaches the pin with no lead ahead of trip.
  assign meas_mag     = mag_req;
  assign fault_type   = mag_req[2:0]; // Fault code traceable to the level.
  assign blk_in       = blk_req;
  assign test_mode_in = tm_req;
endmodule

// [bench/prot_stage_tb_top.sv]
// Self-checking bench for the protection stage.
// Assumes a 20-clock program cycle and the pin model beside it.
`timescale 1ns/1ns
`include "prot_params.svh"
module protection_stage_timing_tb_top;
  import prot_pkg::*;

  localparam int C = 20;

  logic        mclk = 0;
  logic        rst_b = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [15:0] mag = 0;
  logic        blk = 0;
  logic        tm = 0;
  logic [15:0] meas_mag;
  logic [2:0]  fault_type;
  logic        blk_in;
  logic        test_mode_in;
  stat_s       stat;
  logic        disp_evt;
  logic        blk_evt;
  evt_s        evt_rec;
  int          n;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          inv [3][3] = '{'{1, 2, 5}, '{1, 12, 12}, '{3, 0, 10}};
  // Register rows: write, address, data, read value, error.
  logic [31:0] rows [9][5] = '{
    '{0, `OFS_CTRL, 0, 0, 0},
    '{0, `OFS_PICKUP, 0, 'h100, 0},
    '{0, `OFS_DELAY, 0, 8, 0},
    '{0, `OFS_TDIAL, 0, 5, 0},
    '{0, 'h80, 0, 'h64, 0},
    '{1, `OFS_STATUS, 1, 0, 1},
    '{0, 'h40, 0, 0, 1},
    '{1, `OFS_DELAY, 3, 0, 0},
    '{0, `OFS_DELAY, 0, 3, 0}};

  meas_model mm_u (.mag_req(mag), .blk_req(blk), .tm_req(tm),
    .meas_mag(meas_mag), .fault_type(fault_type), .blk_in(blk_in),
    .test_mode_in(test_mode_in));
  prot_stage #(.CYCLE_CLKS(C)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_mag(meas_mag), .fault_type(fault_type),
    .blk_in(blk_in), .test_mode_in(test_mode_in), .stat(stat),
    .disp_evt(disp_evt), .blk_evt(blk_evt), .evt_rec(evt_rec));

  // ------
  // Tasks
  // ------
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50)
      n_fail++;
  endtask

  // Waits for one stage flag, counting clocks, with a bound.
  task automatic wt(input int b, input logic v);
    n = 0;
    while (stat[b] !== v && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 2000)
      n_fail++;
  endtask

  task automatic put(input logic [15:0] m, input logic b, input logic t);
    @(posedge mclk);
    mag <= m;
    blk <= b;
    tm  <= t;
  endtask

  // Clears inputs and lets the stage settle back to idle.
  task automatic clr();
    put(0, 0, 0);
    wt(2, 0);
    wt(1, 0);
    repeat (3 * C) @(posedge mclk);
    $display("test done at cycle %0d", cyc);
  endtask

  always #10 mclk = ~mclk;

  // Cuts a hang short.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i])
    begin
      apb(rows[i][0][0], rows[i][1][7:0], rows[i][2]);
      chk("pslverr", rows[i][4], er);
      if (rows[i][0] == 0) chk("prdata", rows[i][3], rd);
    end
    $display("test done: registers");
    put(16'h12C, 0, 0);
    wt(2, 1);
    chk("pickup", 1, stat.pickup);
    wt(0, 1);
    chk("dt time", 3 * C, n);
    put(16'hF9, 0, 0);
    repeat (3 * C) @(posedge mclk);
    chk("hold", 1, stat.pickup);
    put(16'hF8, 0, 0);
    wt(3, 0);
    chk("drop", 1, n <= 2 * C);
    clr();
    apb(1, `OFS_DELAY, 0);
    put(16'h12C, 0, 0);
    wt(2, 1);
    chk("instant", 1, stat.trip);
    clr();
    apb(1, `OFS_DELAY, 10);
    apb(1, `OFS_RELEASE, 2);
    put(16'h12C, 0, 0);
    wt(2, 1);
    repeat (2 * C) @(posedge mclk);
    put(0, 0, 0);
    wt(2, 0);
    apb(0, `OFS_STATUS, 0);
    chk("release", 32'h100, rd);
    repeat (2 * C) @(posedge mclk);
    apb(0, `OFS_STATUS, 0);
    chk("release held", 32'h100, rd);
    repeat (12 * C) @(posedge mclk);
    chk("abandon", 0, stat.trip);
    put(16'h12C, 0, 0);
    wt(2, 1);
    put(16'h12C, 1, 0);
    wt(2, 0);
    chk("blk event", 1, blk_evt);
    chk("fault", 4, evt_rec.fault);
    repeat (12 * C) @(posedge mclk);
    chk("no trip", 0, stat.trip);
    clr();
    put(0, 1, 0);
    repeat (C) @(posedge mclk);
    put(16'h12C, 1, 0);
    wt(1, 1);
    chk("no start", 0, stat.start);
    chk("disp evt", 1, disp_evt);
    chk("rec mag", 16'h12C, evt_rec.mag);
    clr();
    apb(1, `OFS_CTRL, 8);
    put(16'h12C, 0, 1);
    wt(1, 1);
    chk("sw block", 0, stat.start);
    clr();
    apb(1, 8'hC0, 32'hC8);
    foreach (inv[i])
    begin
      apb(1, `OFS_CTRL, inv[i][0]);
      apb(1, `OFS_DELAY, inv[i][1]);
      put(16'h12C, 0, 0);
      wt(2, 1);
      wt(0, 1);
      chk("inverse_time_mode time", inv[i][2] * C, n);
      clr();
    end
    put(16'h100, 0, 0);
    apb(1, `OFS_CTRL, 4);
    put(16'h80, 0, 0);
    wt(2, 1);
    chk("under trip", 1, stat.trip);
    put(16'h107, 0, 0);
    repeat (3 * C) @(posedge mclk);
    chk("under hold", 1, stat.pickup);
    put(16'h108, 0, 0);
    wt(3, 0);
    chk("under drop", 1, n <= 2 * C);
    put(16'h100, 0, 0);
    $display("test done: under mode");
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("rst stat", 0, stat);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(0, `OFS_CTRL, 0);
    chk("rst ctrl", 0, rd);
    final_report();
  end
endmodule
